/* logic/brake_field_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module brake_field_decode (
  // Raw fields
  input wire reverse_brake_pkg::brake_cfg_t cfg_i,
  input wire logic reverse_run_enable_i,
  // Decoded settings
  output logic [19:0] lin_accel_o,
  output logic [19:0] quad_accel_o,
  output logic [6:0] limit_pct_o,
  output logic [9:0] kp_o,
  output logic [9:0] ki_o
);
  wire [6:0] limit_ext;
  assign limit_ext = {4'h0, cfg_i.limit_code};
  assign lin_accel_o = reverse_run_enable_i ? reverse_brake_pkg::lin_accel(cfg_i.lin_code) : 20'h0;
  assign quad_accel_o = reverse_run_enable_i ?
      reverse_brake_pkg::quad_accel(cfg_i.quad_code) : 20'h0;
  assign limit_pct_o = 7'((limit_ext + 7'h01) * reverse_brake_pkg::LIMIT_STEP_PCT);
  assign kp_o = cfg_i.kp;
  assign ki_o = cfg_i.ki;
endmodule : brake_field_decode
`default_nettype wire

/* logic/reverse_brake_pkg.sv */
`default_nettype none
package reverse_brake_pkg;
  // Register map
  localparam logic [7:0] CFG_OFFSET = 8'h82;
  localparam logic [7:0] REVERSE_RUN_OFFSET = 8'h80;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h7FFF_FFFF;
  localparam logic [31:0] REVERSE_RUN_MASK = 32'h0800_0000;
  localparam int REVERSE_RUN_BIT = 27;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Field positions
  localparam int LIN_LSB = 27;
  localparam int QUAD_LSB = 23;
  localparam int LIMIT_LSB = 20;
  localparam int KP_LSB = 10;
  localparam int KI_LSB = 0;
  // Gain scaling shifts: Kp = field / 2^7, Ki = field / 2^9
  localparam int KP_FRAC_BITS = 7;
  localparam int KI_FRAC_BITS = 9;
  // Current limit step in percent of full-scale current
  localparam logic [6:0] LIMIT_STEP_PCT = 7'h0A;

  typedef struct packed {
    logic [3:0] lin_code;
    logic [3:0] quad_code;
    logic [2:0] limit_code;
    logic [9:0] kp;
    logic [9:0] ki;
  } brake_cfg_t;

  // Acceleration tables in units of 0.01 Hz/s (or Hz/s^2)
  function automatic logic [19:0] lin_accel(input logic [3:0] c);
    case (c)
      4'h0: lin_accel = 20'h00001;
      4'h1: lin_accel = 20'h00005;
      4'h2: lin_accel = 20'h00064;
      4'h3: lin_accel = 20'h000FA;
      4'h4: lin_accel = 20'h001F4;
      4'h5: lin_accel = 20'h003E8;
      4'h6: lin_accel = 20'h009C4;
      4'h7: lin_accel = 20'h01388;
      4'h8: lin_accel = 20'h01D4C;
      4'h9: lin_accel = 20'h02710;
      4'hA: lin_accel = 20'h061A8;
      4'hB: lin_accel = 20'h0C350;
      4'hC: lin_accel = 20'h124F8;
      4'hD: lin_accel = 20'h186A0;
      4'hE: lin_accel = 20'h30D40;
      default: lin_accel = 20'hF4240;
    endcase
  endfunction : lin_accel

  function automatic logic [19:0] quad_accel(input logic [3:0] c);
    if (c == 4'h0) begin
      quad_accel = 20'h00000;
    end else begin
      quad_accel = lin_accel(c);
    end
  endfunction : quad_accel
endpackage : reverse_brake_pkg
`default_nettype wire

/* logic/reverse_brake_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - One 32-bit config register at offset 0x82, reset to zero, bits 30..0 read/write.
// - Bits 30..27 select the reverse linear acceleration from 0.01 to 10000 Hz/s.
// - Bits 26..23 select the reverse quadratic acceleration from 0 to 10000 Hz/s2.
// - Bits 22..20 give the braking bus current limit, 10 percent per code plus 10.
// - Bits 19..10 are the braking proportional gain, value over 128.
// - Bits 9..0 are the braking integral gain, value over 512.
// - Acceleration settings apply only while the reverse run enable bit is set.
module reverse_brake_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Decoded settings
  output logic [19:0] lin_accel_o,
  output logic [19:0] quad_accel_o,
  output logic [6:0] limit_pct_o,
  output logic [9:0] kp_o,
  output logic [9:0] ki_o,
  output logic reverse_run_enable_o
);
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic reverse_run_r;
  logic reverse_run_nxt;
  logic ack_r;
  logic [31:0] readdata_r;
  logic [31:0] readdata_nxt;
  wire req;
  wire hit_cfg;
  wire hit_run;
  wire [31:0] be_mask;
  wire [31:0] run_word;
  reverse_brake_pkg::brake_cfg_t cfg_fields;

  // One wait state: answer on the second edge of a request
  assign req = (read_i | write_i) & ~ack_r;
  assign waitrequest_o = (read_i | write_i) & ~ack_r;
  assign hit_cfg = (address_i == reverse_brake_pkg::CFG_OFFSET);
  assign hit_run = (address_i == reverse_brake_pkg::REVERSE_RUN_OFFSET);

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_be
      assign be_mask[b*8 +: 8] = {8{byteenable_i[b]}};
    end
  endgenerate

  // top bit dropped
  // Writes land only on the edge that sees waitrequest low, as the master expects
  assign cfg_nxt = (ack_r && write_i && hit_cfg) ?
      ((cfg_r & ~(be_mask & reverse_brake_pkg::CFG_WRITE_MASK)) |
       (writedata_i & be_mask & reverse_brake_pkg::CFG_WRITE_MASK)) : cfg_r;
  assign reverse_run_nxt = (ack_r && write_i && hit_run && byteenable_i[3]) ?
      writedata_i[reverse_brake_pkg::REVERSE_RUN_BIT] : reverse_run_r;
  assign run_word = reverse_run_r ? reverse_brake_pkg::REVERSE_RUN_MASK : 32'h0000_0000;
  assign readdata_nxt = hit_cfg ? cfg_r :
      (hit_run ? run_word : reverse_brake_pkg::UNMAPPED_DATA);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_r <= reverse_brake_pkg::CFG_RESET;
      reverse_run_r <= 1'b0;
      ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      reverse_run_r <= reverse_run_nxt;
      ack_r <= req;
      if (req && read_i) begin
        readdata_r <= readdata_nxt;
      end
    end
  end

  assign readdata_o = readdata_r;
  assign reverse_run_enable_o = reverse_run_r;

  assign cfg_fields.lin_code = cfg_r[reverse_brake_pkg::LIN_LSB +: 4];
  assign cfg_fields.quad_code = cfg_r[reverse_brake_pkg::QUAD_LSB +: 4];
  assign cfg_fields.limit_code = cfg_r[reverse_brake_pkg::LIMIT_LSB +: 3];
  assign cfg_fields.kp = cfg_r[reverse_brake_pkg::KP_LSB +: 10];
  assign cfg_fields.ki = cfg_r[reverse_brake_pkg::KI_LSB +: 10];

  brake_field_decode u_decode (
    .cfg_i(cfg_fields),
    .reverse_run_enable_i(reverse_run_r),
    .lin_accel_o(lin_accel_o),
    .quad_accel_o(quad_accel_o),
    .limit_pct_o(limit_pct_o),
    .kp_o(kp_o),
    .ki_o(ki_o)
  );
endmodule : reverse_brake_regs
`default_nettype wire

/* test/reverse_brake_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reverse_brake_regs_bench;
  logic clk_i = 1'b0, resetn_i = 1'b0, read_i = 1'b0, write_i = 1'b0, waitrequest_o;
  logic [7:0] address_i = 8'h00;
  logic [31:0] writedata_i = 32'h0, readdata_o, rd, d;
  logic [3:0] byteenable_i = 4'h0;
  logic reverse_run_enable_o;
  logic [19:0] lin_accel_o, quad_accel_o;
  logic [6:0] limit_pct_o;
  logic [9:0] kp_o, ki_o;
  int err_count = 0, checks_done = 0;
  // Linear table in 0.01 Hz/s steps; quadratic shares it except code 0
  logic [19:0] lin_tab [16] = '{20'h00001, 20'h00005, 20'h00064, 20'h000FA, 20'h001F4,
    20'h003E8, 20'h009C4, 20'h01388, 20'h01D4C, 20'h02710, 20'h061A8, 20'h0C350,
    20'h124F8, 20'h186A0, 20'h30D40, 20'hF4240};
  reverse_brake_regs dut (.clk_i, .resetn_i, .address_i, .read_i, .write_i, .writedata_i,
    .byteenable_i, .readdata_o, .waitrequest_o, .lin_accel_o, .quad_accel_o, .limit_pct_o,
    .kp_o, .ki_o, .reverse_run_enable_o);
  initial forever #10 clk_i = ~clk_i;
  function automatic logic [31:0] exp_limit(input logic [2:0] c);
    exp_limit = ({29'h0, c} + 32'h1) * 32'hA;
  endfunction : exp_limit
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low, then releases
  // No limit of its own: only the watchdog ends a hang
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
    input logic [3:0] be);
    address_i <= a;
    write_i <= wr;
    read_i <= !wr;
    writedata_i <= wd;
    byteenable_i <= be;
    do begin
      @(posedge clk_i);
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(53));
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    bus(8'h82, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0);
    chk({25'h0, limit_pct_o}, 32'h0000000A);
    chk({31'h0, reverse_run_enable_o}, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $urandom;
      bus(8'h82, 1'b1, d, 4'hF);
      bus(8'h82, 1'b0, 32'h0, 4'hF);
      chk(rd, d & 32'h7FFFFFFF);
      chk({25'h0, limit_pct_o}, exp_limit(d[22:20]));
      chk({12'h0, kp_o, ki_o}, {12'h0, d[19:10], d[9:0]});
    end
    bus(8'h82, 1'b1, 32'h0, 4'hF);
    bus(8'h82, 1'b1, 32'hFFFFFFFF, 4'h1);
    bus(8'h84, 1'b1, 32'hFFFFFFFF, 4'hF);
    bus(8'h82, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h000000FF);
    bus(8'h84, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0);
    $display("field test done");
    bus(8'h80, 1'b1, 32'h08000000, 4'h8);
    bus(8'h80, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h08000000);
    chk({31'h0, reverse_run_enable_o}, 32'h1);
    for (int c = 0; c < 16; c++) begin
      bus(8'h82, 1'b1, {1'b0, 4'(c), 4'(c), 23'h0}, 4'hF);
      chk({12'h0, lin_accel_o}, {12'h0, lin_tab[c]});
      chk({12'h0, quad_accel_o}, (c == 0) ? 32'h0 : {12'h0, lin_tab[c]});
    end
    bus(8'h80, 1'b1, 32'h0, 4'hF);
    chk({31'h0, reverse_run_enable_o}, 32'h0);
    chk({11'h0, lin_accel_o, quad_accel_o == 20'h0}, 32'h1);
    $display("accel test done");
    report_and_stop();
  end
endmodule : reverse_brake_regs_bench
`default_nettype wire

/* test/reverse_brake_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module reverse_brake_regs_properties (
  // Clock, reset, bus
  input wire logic clk_i, resetn_i, read_i, write_i, waitrequest_o,
  input wire logic [7:0] address_i,
  input wire logic [31:0] writedata_i, readdata_o,
  input wire logic [3:0] byteenable_i,
  // Decoded settings
  input wire logic reverse_run_enable_o,
  input wire logic [19:0] lin_accel_o, quad_accel_o,
  input wire logic [6:0] limit_pct_o,
  input wire logic [9:0] kp_o, ki_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic ack = (read_i | write_i) & !waitrequest_o;
  wire logic wcfg = write_i & !waitrequest_o & (address_i == 8'h82);
  a_one_wait: assert property ((read_i | write_i) & waitrequest_o |=> !waitrequest_o)
    else $error("no ack after one wait");
  a_unmapped_zero: assert property (read_i & ack & address_i != 8'h82 & address_i != 8'h80
    |-> readdata_o == 32'h0) else $error("unmapped read not zero");
  a_top_bit: assert property (read_i & ack |-> !readdata_o[31]) else $error("bit 31 set");
  a_limit_decode: assert property (wcfg & byteenable_i[2] |=> limit_pct_o ==
    ({4'h0, $past(writedata_i[22:20])} + 7'h01) * 7'h0A) else $error("limit wrong");
  a_kp_load: assert property (wcfg & (&byteenable_i[2:1]) |=> kp_o == $past(writedata_i[19:10]))
    else $error("kp wrong");
  a_ki_load: assert property (wcfg & (&byteenable_i[1:0]) |=> ki_o == $past(writedata_i[9:0]))
    else $error("ki wrong");
  a_run_gate: assert property (!reverse_run_enable_o |-> lin_accel_o == 20'h0
    && quad_accel_o == 20'h0) else $error("accel while disabled");
  a_lin_range: assert property (reverse_run_enable_o |-> lin_accel_o inside
    {[20'h00001:20'hF4240]}) else $error("linear accel out of range");
  a_quad_zero: assert property (wcfg & (&byteenable_i[3:2]) & writedata_i[26:23] == 4'h0
    |=> quad_accel_o == 20'h0) else $error("quad code 0 not zero");
  c_cfg_write: cover property (wcfg);
  c_read: cover property (read_i & ack);
  c_top_code: cover property (lin_accel_o == 20'hF4240);
endmodule : reverse_brake_regs_properties
bind reverse_brake_regs reverse_brake_regs_properties chk (.clk_i, .resetn_i, .read_i,
  .write_i, .waitrequest_o, .address_i, .writedata_i, .readdata_o, .byteenable_i,
  .reverse_run_enable_o, .lin_accel_o, .quad_accel_o, .limit_pct_o, .kp_o, .ki_o);
`default_nettype wire
